//--- rtl/rap_bank_timer.sv
// rap_bank_timer: per-bank row active, read to precharge and pending
// auto precharge tracking for one bank.
// assumes command strobes are one-cycle pulses on core_clk.
`timescale 1ns/1ps
`default_nettype none
module rap_bank_timer (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic act_hit,
  input wire logic rd_hit,
  input wire logic rd_ap,
  input wire logic [rap_pkg::CNT_W-1:0] sched_cyc,
  input wire logic [rap_pkg::CNT_W-1:0] prefetch_cyc,
  output logic pre_start,
  output logic pre_busy,
  output logic row_open
);
  rap_pkg::rap_state_e state_r;
  logic [rap_pkg::CNT_W-1:0] ras_cnt_r;
  logic [rap_pkg::CNT_W-1:0] rtp_cnt_r;
  logic [rap_pkg::CNT_W-1:0] sched_cnt_r;
  logic [rap_pkg::CNT_W-1:0] rp_cnt_r;
  logic row_open_r;
  wire ras_ok = (ras_cnt_r == rap_pkg::CNT_RESET);
  wire rtp_ok = (rtp_cnt_r == rap_pkg::CNT_RESET);
  wire sched_ok = (sched_cnt_r == rap_pkg::CNT_RESET);
  // start only once scheduled edge, tRAS and tRTP all passed
  wire fire = (state_r == rap_pkg::RAP_WAIT) && sched_ok && ras_ok && rtp_ok;
  wire rtp_load = rd_hit;
  // rtp counts from the last prefetch edge plus its own minimum, floor two clocks
  wire [rap_pkg::CNT_W-1:0] rtp_min = (rap_pkg::TRTP_CYC > rap_pkg::PREFETCH_GAP_CYC) ?
                                     rap_pkg::TRTP_CYC : rap_pkg::PREFETCH_GAP_CYC;
  // loaded one short, like the other timers, so zero marks the edge where the minimum is met
  wire [rap_pkg::CNT_W-1:0] rtp_load_val = rap_pkg::CNT_W'(prefetch_cyc + rtp_min - 8'h01);
  assign pre_start = fire;
  assign pre_busy = (state_r == rap_pkg::RAP_PRE);
  assign row_open = row_open_r;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ras_cnt_r <= rap_pkg::CNT_RESET;
    end else if (act_hit) begin
      ras_cnt_r <= rap_pkg::CNT_W'(rap_pkg::TRAS_CYC - 8'h01);
    end else if (!ras_ok) begin
      ras_cnt_r <= rap_pkg::CNT_W'(ras_cnt_r - 8'h01);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rtp_cnt_r <= rap_pkg::CNT_RESET;
    end else if (rtp_load) begin
      rtp_cnt_r <= rtp_load_val;
    end else if (!rtp_ok) begin
      rtp_cnt_r <= rap_pkg::CNT_W'(rtp_cnt_r - 8'h01);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sched_cnt_r <= rap_pkg::CNT_RESET;
    end else if (rd_hit && rd_ap) begin
      sched_cnt_r <= sched_cyc;
    end else if (!sched_ok) begin
      sched_cnt_r <= rap_pkg::CNT_W'(sched_cnt_r - 8'h01);
    end
  end

  ////////////////////////////////////////////////////////////////
  // tRP begins at the cycle the precharge actually fires, not a later edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= rap_pkg::RAP_IDLE;
      rp_cnt_r <= rap_pkg::CNT_RESET;
      row_open_r <= 1'b0;
    end else begin
      case (state_r)
        rap_pkg::RAP_IDLE: begin
          if (act_hit) begin
            row_open_r <= 1'b1;
          end
          if (rd_hit && rd_ap) begin
            state_r <= rap_pkg::RAP_WAIT;
          end
        end
        rap_pkg::RAP_WAIT: begin
          if (fire) begin
            state_r <= rap_pkg::RAP_PRE;
            rp_cnt_r <= rap_pkg::CNT_W'(rap_pkg::TRP_CYC - 8'h01);
            row_open_r <= 1'b0;
          end
        end
        rap_pkg::RAP_PRE: begin
          if (rp_cnt_r == rap_pkg::CNT_RESET) begin
            state_r <= rap_pkg::RAP_IDLE;
          end else begin
            rp_cnt_r <= rap_pkg::CNT_W'(rp_cnt_r - 8'h01);
          end
        end
        default: state_r <= rap_pkg::RAP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  a_fire_after_ras: assert property (@(posedge core_clk) disable iff (srst)
    pre_start |-> ras_ok && rtp_ok) else $error("precharge before row minimum");
  a_rp_len: assert property (@(posedge core_clk) disable iff (srst)
    pre_start |=> pre_busy [*2]) else $error("precharge period cut short");
endmodule : rap_bank_timer
`default_nettype wire

//--- rtl/rap_pkg.sv
// rap_pkg: constants and types for the read auto precharge timing block.
// assumes a 200 MHz core clock standing in for CK, eight banks.
package rap_pkg;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int CNT_W = 8;
  localparam int CLK_PERIOD_PS = 5000;
  // row active, read to precharge and precharge period minimums in ps, least times round up
  localparam int TRAS_MIN_PS = 40000;
  localparam int TRTP_MIN_PS = 7500;
  localparam int TRP_MIN_PS = 12500;
  localparam logic [CNT_W-1:0] TRAS_CYC = CNT_W'((TRAS_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] TRTP_CYC = CNT_W'((TRTP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] TRP_CYC = CNT_W'((TRP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // least gap from last prefetch edge to internal precharge
  localparam logic [CNT_W-1:0] PREFETCH_GAP_CYC = 8'h02;
  // offset of the last 4-bit prefetch after the posted read for burst of eight
  localparam logic [CNT_W-1:0] BL8_PREFETCH_OFS = 8'h02;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [2:0] AL_RESET = 3'h0;
  localparam logic [2:0] CL_RESET = 3'h3;
  typedef enum logic [1:0] {RAP_IDLE, RAP_WAIT, RAP_PRE} rap_state_e;
endpackage : rap_pkg

//--- rtl/rap_timing.sv
// rap_timing: read with auto precharge timing for all banks.
// assumes the command decoder presents one decoded command per cycle,
// and the mode registers present al and cl codes and the burst length.
//
// Behaviour
// - read with address bit ten high closes its row after the burst
// - internal precharge starts al plus half burst cycles after the read
// - postpone precharge until row active and read to precharge minimums pass
// - precharge period starts at the actual internal precharge instant
// - precharge never earlier than two clocks after last prefetch edge
// - auto precharge read on one bank while other banks keep working
// - sixteen-bit part: lower strobe with lower byte, upper with upper
// - read latency equals additive latency plus cas latency
// - read to precharge counted from last prefetch edge
`timescale 1ns/1ps
`default_nettype none
module rap_timing (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cmd_act,
  input wire logic cmd_read,
  input wire logic [rap_pkg::BANK_W-1:0] cmd_bank,
  input wire logic addr_a10,
  input wire logic [2:0] mode_al,
  input wire logic [2:0] mode_cl,
  input wire logic burst8,
  input wire logic rd_lane_lo,
  input wire logic rd_lane_hi,
  output logic [rap_pkg::NUM_BANKS-1:0] bank_pre_start,
  output logic [rap_pkg::NUM_BANKS-1:0] bank_pre_busy,
  output logic [rap_pkg::NUM_BANKS-1:0] bank_row_open,
  output logic [rap_pkg::CNT_W-1:0] read_latency,
  output logic ldqs_en,
  output logic udqs_en
);
  logic [rap_pkg::CNT_W-1:0] rl_r;
  logic ldqs_r;
  logic udqs_r;
  wire [rap_pkg::CNT_W-1:0] al_ext = {5'h00, mode_al};
  wire [rap_pkg::CNT_W-1:0] half_bl = burst8 ? 8'h04 : 8'h02;
  // scheduled edge is al plus bl/2 after the command; counter hits zero there
  wire [rap_pkg::CNT_W-1:0] sched_cyc = rap_pkg::CNT_W'(al_ext + half_bl - 8'h01);
  // last prefetch starts al (bl4) or al plus two (bl8) after the command
  wire [rap_pkg::CNT_W-1:0] prefetch_cyc = burst8 ? rap_pkg::CNT_W'(al_ext + rap_pkg::BL8_PREFETCH_OFS)
                                                  : al_ext;
  wire [rap_pkg::CNT_W-1:0] rl_nxt = rap_pkg::CNT_W'(al_ext + {5'h00, mode_cl});

  // each bank timer runs alone, so other banks keep taking commands
  genvar b;
  generate
    for (b = 0; b < rap_pkg::NUM_BANKS; b++) begin : g_bank
      wire hit = (cmd_bank == rap_pkg::BANK_W'(b));
      rap_bank_timer u_bank (
        .core_clk(core_clk),
        .srst(srst),
        .act_hit(cmd_act && hit),
        .rd_hit(cmd_read && hit),
        .rd_ap(addr_a10),
        .sched_cyc(sched_cyc),
        .prefetch_cyc(prefetch_cyc),
        .pre_start(bank_pre_start[b]),
        .pre_busy(bank_pre_busy[b]),
        .row_open(bank_row_open[b])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rl_r <= rap_pkg::CNT_W'(rap_pkg::AL_RESET) + rap_pkg::CNT_W'(rap_pkg::CL_RESET);
      ldqs_r <= 1'b0;
      udqs_r <= 1'b0;
    end else begin
      rl_r <= rl_nxt;
      ldqs_r <= rd_lane_lo;
      udqs_r <= rd_lane_hi;
    end
  end
  assign read_latency = rl_r;
  assign ldqs_en = ldqs_r;
  assign udqs_en = udqs_r;

  ////////////////////////////////////////////////////////////////
  a_rl_sum: assert property (@(posedge core_clk) disable iff (srst)
    ##1 read_latency == rap_pkg::CNT_W'($past(mode_al) + $past(mode_cl))) else $error("latency mismatch");
  a_lane_lo: assert property (@(posedge core_clk) disable iff (srst)
    rd_lane_lo |=> ldqs_en) else $error("lower strobe not following lower byte");
  a_lane_hi: assert property (@(posedge core_clk) disable iff (srst)
    rd_lane_hi |=> udqs_en) else $error("upper strobe not following upper byte");
  a_no_early_pre: assert property (@(posedge core_clk) disable iff (srst)
    (cmd_read && addr_a10 && !burst8 && mode_al == 3'h0 && cmd_bank == 3'h0) |=> !bank_pre_start[0])
    else $error("precharge too early");
  a_bl4_sched: assert property (@(posedge core_clk) disable iff (srst)
    (cmd_read && addr_a10 && cmd_bank == 3'h1 && !burst8 && mode_al == 3'h0) |-> ##1 !bank_pre_start[1])
    else $error("precharge before scheduled edge");
  a_ap_closes: assert property (@(posedge core_clk) disable iff (srst)
    bank_pre_start[2] |=> !bank_row_open[2] && bank_pre_busy[2]) else $error("row not closed");
  a_one_bank: assert property (@(posedge core_clk) disable iff (srst)
    bank_pre_start[3] |-> !bank_pre_busy[3]) else $error("double precharge");
  a_ras_wait: assert property (@(posedge core_clk) disable iff (srst)
    (cmd_act && cmd_bank == 3'h4) |=> !bank_pre_start[4] [*7]) else $error("row minimum not kept");
endmodule : rap_timing
`default_nettype wire

//--- tb/rap_ctrl_model.sv
// rap_ctrl_model: controller side, issues activate and read commands.
// assumes rap_pkg timing constants and a free running core_clk.
`timescale 1ns/1ps
`default_nettype none
module rap_ctrl_model (
  input wire logic core_clk,
  output logic cmd_act,
  output logic cmd_read,
  output logic [rap_pkg::BANK_W-1:0] cmd_bank,
  output logic addr_a10
);
  localparam int RTP_RP = (rap_pkg::TRTP_MIN_PS + rap_pkg::TRP_MIN_PS + rap_pkg::CLK_PERIOD_PS - 1)
    / rap_pkg::CLK_PERIOD_PS;
  int cyc = 0;
  int act_ok [rap_pkg::NUM_BANKS] = '{default: 0};
  int rd_ok = 0;
  // earliest explicit precharge per bank, kept for plain reads
  int pre_ok [rap_pkg::NUM_BANKS] = '{default: 0};
  initial begin
    cmd_act = 1'b0;
    cmd_read = 1'b0;
    cmd_bank = '0;
    addr_a10 = 1'b0;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  ////////////////////////////////////////
  // released address lines flip so a held copy is never mistaken for a command
  task automatic issue(input logic act, input logic rd, input logic [2:0] b, input logic ap);
    @(posedge core_clk);
    #1;
    cmd_act = act;
    cmd_read = rd;
    cmd_bank = b;
    addr_a10 = ap;
    @(posedge core_clk);
    #1;
    cmd_act = 1'b0;
    cmd_read = 1'b0;
    cmd_bank = ~b;
    addr_a10 = ~ap;
  endtask : issue
  task automatic activate(input logic [2:0] b);
    while (cyc < act_ok[b]) @(posedge core_clk);
    issue(1'b1, 1'b0, b, 1'b0);
    pre_ok[b] = cyc + int'(rap_pkg::TRAS_CYC);
  endtask : activate
  task automatic read(input logic [2:0] b, input logic ap, input int al, input logic bl8);
    int gap;
    while (cyc < rd_ok) @(posedge core_clk);
    issue(1'b0, 1'b1, b, ap);
    gap = al + (bl8 ? 4 : 2) - 2 + (int'(rap_pkg::TRTP_CYC) > 2 ? int'(rap_pkg::TRTP_CYC) : 2);
    if (!ap && cyc + gap > pre_ok[b]) pre_ok[b] = cyc + gap;
    rd_ok = cyc + (bl8 ? 4 : 2);
    if (ap) act_ok[b] = cyc + al + (bl8 ? 2 : 0) + RTP_RP;
  endtask : read
endmodule : rap_ctrl_model
`default_nettype wire

//--- tb/testbench.sv
// testbench: scenario tasks for rap_timing driven through a controller model.
// assumes 200 MHz core_clk and synchronous active high srst.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] mode_al = 3'h0;
  logic [2:0] mode_cl = 3'h3;
  logic burst8 = 1'b0;
  logic rd_lane_lo = 1'b0;
  logic rd_lane_hi = 1'b0;
  wire logic cmd_act, cmd_read, addr_a10;
  wire logic [2:0] cmd_bank;
  logic [7:0] pre_start, pre_busy, row_open, rd_lat;
  logic ldqs_en, udqs_en;
  int fails = 0;
  int check_count = 0;
  rap_ctrl_model i_ctl (.core_clk(core_clk), .cmd_act(cmd_act), .cmd_read(cmd_read), .cmd_bank(cmd_bank),
    .addr_a10(addr_a10));
  rap_timing i_dut (.core_clk(core_clk), .srst(srst), .cmd_act(cmd_act), .cmd_read(cmd_read),
    .cmd_bank(cmd_bank), .addr_a10(addr_a10), .mode_al(mode_al), .mode_cl(mode_cl), .burst8(burst8),
    .rd_lane_lo(rd_lane_lo), .rd_lane_hi(rd_lane_hi), .bank_pre_start(pre_start), .bank_pre_busy(pre_busy),
    .bank_row_open(row_open), .read_latency(rd_lat), .ldqs_en(ldqs_en), .udqs_en(udqs_en));
  initial forever #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////
  task automatic sync();
    @(posedge core_clk);
    #1;
  endtask : sync
  // k counts edges after the taken edge; the pulse is sampled mid-cycle
  task automatic watch(input int b, output int hit);
    hit = 0;
    for (int k = 1; k <= 24; k++) begin
      @(negedge core_clk);
      if (hit == 0 && pre_start[b] === 1'b1) hit = k;
      if (hit != 0 && k > hit && k <= hit + 3) `CHK(pre_busy[b], 1'b1)
      if (hit != 0 && k == hit + 1) `CHK(row_open[b], 1'b0)
    end
  endtask : watch
  task automatic ap_case(input int b, input int al, input logic bl8, input int n);
    int hit;
    int ex;
    int rtp;
    sync();
    mode_al = 3'(al);
    burst8 = bl8;
    rtp = int'(rap_pkg::TRTP_CYC > rap_pkg::PREFETCH_GAP_CYC ? rap_pkg::TRTP_CYC : rap_pkg::PREFETCH_GAP_CYC);
    ex = al + (bl8 ? int'(rap_pkg::BL8_PREFETCH_OFS) : 0) + rtp;
    if (al + (bl8 ? 4 : 2) > ex) ex = al + (bl8 ? 4 : 2);
    if (int'(rap_pkg::TRAS_CYC) - (n + 2) > ex) ex = int'(rap_pkg::TRAS_CYC) - (n + 2);
    i_ctl.activate(3'(b));
    repeat (n) @(posedge core_clk);
    `CHK(row_open[b], 1'b1)
    i_ctl.read(3'(b), 1'b1, al, bl8);
    watch(b, hit);
    `CHK(hit, ex)
    $display("test ap_case bank %0d done", b);
  endtask : ap_case
  task automatic open_case();
    int hit;
    sync();
    i_ctl.activate(3'h3);
    repeat (8) @(posedge core_clk);
    i_ctl.read(3'h3, 1'b0, 0, 1'b0);
    `CHK(i_ctl.pre_ok[3] - i_ctl.cyc, 2)
    watch(3, hit);
    `CHK(hit, 0)
    `CHK(row_open[3], 1'b1)
    $display("test open_case done");
  endtask : open_case
  task automatic conc_case();
    int h1;
    int h2;
    sync();
    mode_al = 3'h0;
    burst8 = 1'b0;
    i_ctl.activate(3'h1);
    i_ctl.activate(3'h2);
    repeat (8) @(posedge core_clk);
    i_ctl.read(3'h1, 1'b1, 0, 1'b0);
    fork
      watch(1, h1);
      begin
        i_ctl.read(3'h2, 1'b1, 0, 1'b0);
        watch(2, h2);
      end
    join
    `CHK(h1, 2)
    `CHK(h2, 2)
    `CHK(row_open[3], 1'b1)
    $display("test conc_case done");
  endtask : conc_case
  task automatic lat_case();
    for (int i = 0; i < 4; i++) begin
      mode_al = 3'(i + 1);
      mode_cl = 3'(i + 3);
      rd_lane_lo = i[0];
      rd_lane_hi = i[1];
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(rd_lat, 8'(mode_al) + 8'(mode_cl))
      `CHK(ldqs_en, rd_lane_lo)
      `CHK(udqs_en, rd_lane_hi)
    end
    $display("test lat_case done");
  endtask : lat_case
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // whole run is a few hundred cycles; this leaves ample slack
  initial begin
    repeat (2000) @(posedge core_clk);
    fails++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    srst = 1'b0;
    `CHK(row_open, 8'h00)
    `CHK(rd_lat, 8'h03)
    lat_case();
    ap_case(0, 0, 1'b0, 6);
    ap_case(0, 0, 1'b0, 0);
    ap_case(4, 2, 1'b1, 6);
    ap_case(5, 3, 1'b0, 2);
    open_case();
    conc_case();
    close_out();
  end
endmodule : testbench
`undef CHK
`default_nettype wire
